// ==== dv/lvds_link_properties.sv ====
// Concurrent checks on the link wire and the receiver outputs
`default_nettype none
module lvds_link_properties #(
    parameter int BIT_CYC = 4,
    parameter int LOCK_CYC = 20
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] tx_lane,
    input wire logic tx_clk,
    input wire logic tx_clk_oe,
    input wire logic link_clock_in,
    input wire logic power_down_n_i,
    input wire logic [27:0] parallel_pixel_out_o,
    input wire logic regenerated_pixel_clock_o,
    input wire logic locked_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HI_CYC = 4 * BIT_CYC;
    localparam int LO_CYC = 3 * BIT_CYC;
    // Margin past three silent periods so the receiver timeout is never raced
    localparam int LOST_CYC = 21 * BIT_CYC + 16;
    int hi_cnt;
    int lo_cnt;
    int pd_cnt;
    int idle_cnt;
    logic seen_hi;
    logic clk_d;
    wire logic link_rise;
    wire logic pd_steady;
    assign link_rise = link_clock_in && !clk_d;
    assign pd_steady = pd_cnt > 8;

    // Run lengths, each cleared as soon as its condition breaks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_cnt <= 0;
            lo_cnt <= 0;
            pd_cnt <= 0;
            idle_cnt <= 0;
            seen_hi <= 1'b0;
            clk_d <= 1'b0;
        end else begin
            hi_cnt <= (tx_clk_oe && tx_clk) ? hi_cnt + 1 : 0;
            lo_cnt <= (tx_clk_oe && !tx_clk && seen_hi) ? lo_cnt + 1 : 0;
            seen_hi <= tx_clk_oe && (seen_hi || tx_clk);
            pd_cnt <= power_down_n_i ? pd_cnt + 1 : 0;
            idle_cnt <= link_rise ? 0 : idle_cnt + 1;
            clk_d <= link_clock_in;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // A lane bit stands a whole slot unless the sender lets go
    sequence s_slot_hold;
        ##1 ($stable(tx_lane) || !tx_clk_oe) [*3];
    endsequence
    sequence s_unlocked;
        !locked_o [*2];
    endsequence
    property p_clk_high;
        tx_clk_oe && $fell(tx_clk) |-> hi_cnt == HI_CYC;
    endproperty
    property p_clk_low;
        tx_clk_oe && seen_hi && $rose(tx_clk) |-> lo_cnt == LO_CYC;
    endproperty
    property p_slot_hold;
        tx_clk_oe && $rose(tx_clk) |-> s_slot_hold;
    endproperty
    property p_pd_zero;
        !power_down_n_i [*5] |-> parallel_pixel_out_o == 28'h0000000
            && !regenerated_pixel_clock_o && !locked_o;
    endproperty
    property p_lock_wait;
        $rose(locked_o) |-> pd_cnt >= LOCK_CYC;
    endproperty
    property p_unlocked_zero;
        s_unlocked |-> parallel_pixel_out_o == 28'h0000000 && !regenerated_pixel_clock_o;
    endproperty
    property p_strobe;
        pd_steady && $changed(parallel_pixel_out_o) |-> !regenerated_pixel_clock_o;
    endproperty
    property p_lost_low;
        pd_steady && idle_cnt > LOST_CYC |-> !regenerated_pixel_clock_o;
    endproperty
    property p_lost_hold;
        pd_steady && idle_cnt > LOST_CYC |-> $stable(parallel_pixel_out_o);
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("link clock high time wrong");
    a_clk_low: assert property (p_clk_low) else $error("link clock low time wrong");
    a_slot_hold: assert property (p_slot_hold) else $error("lane bit too short");
    a_pd_zero: assert property (p_pd_zero) else $error("outputs live in power-down");
    a_lock_wait: assert property (p_lock_wait) else $error("lock came too early");
    a_unlocked_zero: assert property (p_unlocked_zero) else $error("output before lock");
    a_strobe: assert property (p_strobe) else $error("word moved while clock high");
    a_lost_low: assert property (p_lost_low) else $error("clock out not low");
    a_lost_hold: assert property (p_lost_hold) else $error("word not held");
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench joining both link ends back to back
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic enable_i = 1'b0;
    logic power_down_n_i = 1'b1;
    logic [27:0] pixel_in_i = 28'h0000000;
    logic word_taken_o;
    logic regen;
    logic locked_o;
    logic regen_d = 1'b0;
    logic [27:0] word_o;
    logic [27:0] word_18;
    logic locked_18;
    int fails = 0;
    int tests_run = 0;
    logic [27:0] sent[$];
    logic [27:0] recv[$];
    lvds_link_if lnk();
    lvds_link_if lnk_18();

    lvds_link_tx u_lvds_link_tx (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(lnk.tx), .enable_i(enable_i), .pixel_in_i(pixel_in_i),
        .word_taken_o(word_taken_o));
    lvds_link_rx #(.LOCK_CYC(20)) u_lvds_link_rx (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .link(lnk.rx), .power_down_n_i(power_down_n_i),
        .parallel_pixel_out_o(word_o), .regenerated_pixel_clock_o(regen),
        .locked_o(locked_o));
    // Three-lane build fed by a bench clock with all lanes left floating
    lvds_link_rx #(.NUM_LANES(3), .LOCK_CYC(20)) u_lvds_link_rx_18 (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .link(lnk_18.rx),
        .power_down_n_i(power_down_n_i),
        .parallel_pixel_out_o(word_18), .regenerated_pixel_clock_o(),
        .locked_o(locked_18));
    lvds_link_properties u_lvds_link_properties (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_lane(lnk.tx_lane), .tx_clk(lnk.tx_clk),
        .tx_clk_oe(lnk.tx_clk_oe), .link_clock_in(lnk.link_clock_in),
        .power_down_n_i(power_down_n_i), .parallel_pixel_out_o(word_o),
        .regenerated_pixel_clock_o(regen), .locked_o(locked_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Period is seven slots of four cycles, since the receiver counts fixed slots
    initial begin
        lnk_18.tx_lane = 4'h0;
        lnk_18.tx_lane_oe = 4'h0;
        lnk_18.tx_clk_oe = 1'b1;
        lnk_18.tx_clk = 1'b0;
        #3;
        forever begin
            lnk_18.tx_clk = 1'b1;
            #160;
            lnk_18.tx_clk = 1'b0;
            #120;
        end
    end
    // Capture each word at the strobing edge of the regenerated clock
    always @(negedge clk_i) begin
        if (regen_d && !regen) recv.push_back(word_o);
        regen_d = regen;
    end

    task automatic summarize();
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string name, logic [27:0] exp, logic [27:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_lock();
        int n;
        n = 0;
        while (locked_o !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 200) begin
            fails++;
            summarize();
        end
    endtask
    // Hand over a word, then read its seven slots back off the wire
    task automatic send(logic [27:0] w);
        int n;
        @(posedge clk_i);
        pixel_in_i <= w;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (word_taken_o !== 1'b1 && n < 60);
        if (n >= 60) begin
            fails++;
            summarize();
        end
        sent.push_back(w);
        @(negedge clk_i);
        for (int s = 0; s < 7; s++) begin
            @(negedge clk_i);
            check("link clock", 28'(s < 4), 28'(lnk.tx_clk));
            for (int l = 0; l < 4; l++) begin
                check("lane bit", 28'(w[lvds_link_pkg::LANE_MAP[l][s]]),
                    28'(lnk.tx_lane[l]));
            end
            if (s < 6) repeat (3) @(negedge clk_i);
        end
    endtask
    // Sent words must come out in order, one per period, none lost or doubled
    task automatic check_seq();
        int at;
        at = -1;
        repeat (70) @(negedge clk_i);
        foreach (recv[i]) if (at < 0 && recv[i] === sent[0]) at = i;
        check("first word", 28'(at >= 0), 28'h0000001);
        for (int k = 0; k < sent.size() && at >= 0; k++) begin
            check("rx word", sent[k],
                (at + k < recv.size()) ? recv[at + k] : 28'h0000000);
        end
        sent.delete();
        recv.delete();
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        enable_i <= 1'b1;
        wait_lock();
        for (int i = 0; i < 28; i++) send(28'h0000001 << i);
        check_seq();
        @(posedge clk_i);
        power_down_n_i <= 1'b0;
        repeat (6) @(negedge clk_i);
        check("pd word", 28'h0000000, word_o);
        check("pd clock", 28'h0000000, 28'(regen));
        @(posedge clk_i);
        power_down_n_i <= 1'b1;
        wait_lock();
        send(28'hA5C3E17);
        send(28'h5A3C1E8);
        send(28'hFFFFFFF);
        check_seq();
        @(posedge clk_i);
        enable_i <= 1'b0;
        repeat (150) @(negedge clk_i);
        check("lost clock", 28'h0000000, 28'(regen));
        check("held word", 28'hFFFFFFF, word_o);
        check("floating lanes", 28'h77CF3DF, word_18);
        check("18-bit lock", 28'h0000001, 28'(locked_18));
        summarize();
    end
endmodule
`default_nettype wire

// ==== inc/lvds_link_if.sv ====
// Serial link between transmitter and receiver, with failsafe pull-up of idle lanes
`default_nettype none
interface lvds_link_if;
    logic [lvds_link_pkg::LANES_MAX-1:0] tx_lane;
    logic [lvds_link_pkg::LANES_MAX-1:0] tx_lane_oe;
    logic tx_clk;
    logic tx_clk_oe;
    wire logic [lvds_link_pkg::LANES_MAX-1:0] serial_data_lane;
    wire logic link_clock_in;

    // Undriven lanes and clock read as high
    assign serial_data_lane = tx_lane | ~tx_lane_oe;
    assign link_clock_in = tx_clk | ~tx_clk_oe;

    modport tx (output tx_lane, output tx_lane_oe, output tx_clk, output tx_clk_oe);
    modport rx (input serial_data_lane, input link_clock_in);
endinterface
`default_nettype wire

// ==== inc/lvds_link_pkg.sv ====
// Shared constants for the serial display link transmitter and receiver ends
`default_nettype none
package lvds_link_pkg;
    // Lane and word geometry
    localparam int LANES_MAX = 4;
    localparam int SLOTS = 7;
    localparam int WORD_W = 28;
    localparam int LANES_18BIT = 3;
    localparam logic [2:0] LAST_SLOT = 3'h6;
    // Link clock is high for the first four bit slots of each period
    localparam logic [2:0] CLK_HIGH_SLOTS = 3'h4;

    // Parallel bit carried by each lane in each bit slot
    localparam logic [4:0] LANE_MAP [0:LANES_MAX-1][0:SLOTS-1] = '{
        '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07},
        '{5'h08, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12},
        '{5'h13, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A},
        '{5'h05, 5'h0A, 5'h0B, 5'h10, 5'h11, 5'h17, 5'h1B}
    };

    // Suggested placement of the three control bits and the spare in the word
    localparam int LINE_SYNC_BIT = 24;
    localparam int FRAME_SYNC_BIT = 25;
    localparam int PIXEL_VALID_BIT = 26;
    localparam int SPARE_CONTROL_BIT = 27;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int BIT_CYC_DEF = 4;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_CYC_DEF = LOCK_TIME_MS * CLK_MHZ * 1000;
    // Link clock rate limits in MHz
    localparam int LINK_MHZ_MIN = 20;
    localparam int LINK_MHZ_MAX = 85;
    // Missing link clock edges for this many periods means the clock is gone
    localparam int LOSS_PERIODS = 3;
endpackage
`default_nettype wire

// ==== rtl/lvds_link_rx.sv ====
// Deserializing receiver end of the display link
//
// Notes on behaviour
// - Four-lane build drives 28-bit pixel word
// - Three-lane build carries 21 of those bits
// - Four or three data lanes plus link clock
// - Regenerated clock falling edge strobes the word
// - Power-down low forces all outputs low
// - Floating lanes read as constant high
// - Clock present, lanes floating: word all high (three-lane build: lane 3 bits read low)
// - Clock lost: word holds last valid value
// - Clock lost: regenerated clock held low
// - Lane 0 and lane 1 bit order
// - Lane 2 and lane 3 bit order
// - Colour placement in word is user's choice
// - Seven evenly spaced samples per lane per period
// - Link clock between 20 and 85 MHz (receiver decodes only clk_i/(7*BIT_CYC), 100/28 MHz at the defaults)
// - Output invalid until lock time after power-up
`default_nettype none
module lvds_link_rx #(
    parameter int NUM_LANES = lvds_link_pkg::LANES_MAX,
    parameter int BIT_CYC = lvds_link_pkg::BIT_CYC_DEF,
    parameter int LOCK_CYC = lvds_link_pkg::LOCK_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    lvds_link_if.rx link,
    input wire logic power_down_n_i,
    output logic [lvds_link_pkg::WORD_W-1:0] parallel_pixel_out_o,
    output logic regenerated_pixel_clock_o,
    output logic locked_o
);
    localparam int SUB_W = $clog2(BIT_CYC);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(BIT_CYC - 1);
    // Sample one cycle before the slot midpoint to absorb the edge detector delay
    localparam logic [SUB_W-1:0] SUB_MID = SUB_W'((BIT_CYC - 1) / 2);
    localparam int LOCK_W = $clog2(LOCK_CYC + 1);
    localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYC);
    localparam int LOSS_CYC = lvds_link_pkg::LOSS_PERIODS * lvds_link_pkg::SLOTS * BIT_CYC;
    localparam int LOSS_W = $clog2(LOSS_CYC + 1);
    localparam logic [LOSS_W-1:0] LOSS_LAST = LOSS_W'(LOSS_CYC);

    typedef enum logic [3:0] {
        ST_DOWN = 4'h1,
        ST_LOCK = 4'h2,
        ST_RUN = 4'h4,
        ST_LOST = 4'h8
    } rx_state_type;

    rx_state_type state;
    rx_state_type next_state;

    // Synchroniser stages for every pin
    logic [lvds_link_pkg::LANES_MAX-1:0] lane_meta;
    logic [lvds_link_pkg::LANES_MAX-1:0] lane_sync;
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic pd_meta;
    logic pd_sync;

    logic [LOCK_W-1:0] lock_cnt;
    logic [LOSS_W-1:0] loss_cnt;
    logic [SUB_W-1:0] sub;
    logic [2:0] slot;
    logic run;
    logic load;
    logic [lvds_link_pkg::WORD_W-1:0] asm_word;

    // Lanes and link clock pass two flip-flops; all pins share the same delay
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lane_meta <= '0;
            lane_sync <= '0;
            clk_meta <= 1'b1;
            clk_sync <= 1'b1;
            clk_prev <= 1'b1; // Idle pin floats high; avoids a false edge after reset
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
        end else begin
            lane_meta <= link.serial_data_lane;
            lane_sync <= lane_meta;
            clk_meta <= link.link_clock_in;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
            pd_meta <= power_down_n_i;
            pd_sync <= pd_meta;
        end
    end

    // Rising link clock edge marks the start of bit slot 0
    wire clk_rise = clk_sync && !clk_prev;
    wire clk_present = (loss_cnt != LOSS_LAST);
    wire lock_done = (lock_cnt == LOCK_LAST);
    wire strobe = run && (sub == SUB_MID);
    wire last_strobe = strobe && (slot == lvds_link_pkg::LAST_SLOT);

    // Lock timer restarts on every power-up or power-down exit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_cnt <= '0;
        end else if (!pd_sync) begin
            lock_cnt <= '0;
        end else if (!lock_done) begin
            lock_cnt <= lock_cnt + LOCK_W'(1);
        end
    end

    // Clock watchdog; a floating clock reads steady high and gives no edges
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loss_cnt <= LOSS_LAST;
        end else if (clk_rise) begin
            loss_cnt <= '0;
        end else if (clk_present) begin
            loss_cnt <= loss_cnt + LOSS_W'(1);
        end
    end

    // Mode selection
    always_comb begin
        next_state = state;
        case (state)
            ST_DOWN: begin
                if (pd_sync) begin
                    next_state = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (!pd_sync) begin
                    next_state = ST_DOWN;
                end else if (lock_done) begin
                    next_state = clk_present ? ST_RUN : ST_LOST;
                end
            end
            ST_RUN: begin
                if (!pd_sync) begin
                    next_state = ST_DOWN;
                end else if (!clk_present) begin
                    next_state = ST_LOST;
                end
            end
            ST_LOST: begin
                if (!pd_sync) begin
                    next_state = ST_DOWN;
                end else if (clk_present) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_DOWN;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_DOWN;
        end else begin
            state <= next_state;
        end
    end

    // Slot counter; each period re-aligns to the link clock so drift never builds up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sub <= '0;
            slot <= 3'h0;
            run <= 1'b0;
        end else if (clk_rise) begin
            sub <= '0;
            slot <= 3'h0;
            run <= 1'b1;
        end else if (run) begin
            if (sub == SUB_LAST) begin
                sub <= '0;
                if (slot == lvds_link_pkg::LAST_SLOT) begin
                    run <= 1'b0;
                end else begin
                    slot <= slot + 3'h1;
                end
            end else begin
                sub <= sub + SUB_W'(1);
            end
        end
    end

    // Each lane sample lands on its mapped word bit; missing lanes give zeros
    for (genvar l = 0; l < lvds_link_pkg::LANES_MAX; l++) begin : g_lane
        for (genvar s = 0; s < lvds_link_pkg::SLOTS; s++) begin : g_slot
            wire take = strobe && (slot == 3'(s));
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    asm_word[lvds_link_pkg::LANE_MAP[l][s]] <= 1'b0;
                end else if (take) begin
                    asm_word[lvds_link_pkg::LANE_MAP[l][s]] <= (l < NUM_LANES) && lane_sync[l];
                end
            end
        end
    end

    // Word is complete one cycle after the last slot is sampled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load <= 1'b0;
        end else begin
            load <= last_strobe;
        end
    end

    // Outputs: zero while down or locking, held while the clock is lost
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            parallel_pixel_out_o <= '0;
            regenerated_pixel_clock_o <= 1'b0;
            locked_o <= 1'b0;
        end else begin
            locked_o <= (state == ST_RUN) || (state == ST_LOST);
            if ((state == ST_DOWN) || (state == ST_LOCK) || !pd_sync) begin
                parallel_pixel_out_o <= '0;
                regenerated_pixel_clock_o <= 1'b0;
            end else if (state == ST_LOST) begin
                regenerated_pixel_clock_o <= 1'b0;
            end else begin
                if (load) begin
                    // Floating lanes read high, so a live clock yields ones on built lanes, zeros for missing lanes
                    parallel_pixel_out_o <= asm_word;
                end
                // Word changes during the low phase, stable across the falling edge
                regenerated_pixel_clock_o <= run && (slot < lvds_link_pkg::CLK_HIGH_SLOTS);
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/lvds_link_tx.sv ====
// Serializing transmitter end of the display link
`default_nettype none
module lvds_link_tx #(
    parameter int NUM_LANES = lvds_link_pkg::LANES_MAX,
    parameter int BIT_CYC = lvds_link_pkg::BIT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    lvds_link_if.tx link,
    input wire logic enable_i,
    input wire logic [lvds_link_pkg::WORD_W-1:0] pixel_in_i,
    output logic word_taken_o
);
    localparam int SUB_W = $clog2(BIT_CYC);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(BIT_CYC - 1);

    logic [SUB_W-1:0] sub;
    logic [2:0] slot;
    logic [lvds_link_pkg::WORD_W-1:0] hold;
    logic drive;
    logic clk_q;
    logic [lvds_link_pkg::LANES_MAX-1:0] lane_q;

    wire period_end = (sub == SUB_LAST) && (slot == lvds_link_pkg::LAST_SLOT);
    wire load = enable_i && period_end;

    // One word is taken at the start of every link period
    assign word_taken_o = load;

    // Bit slot divider; parked on the last slot while idle so the first period loads
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sub <= SUB_LAST;
            slot <= lvds_link_pkg::LAST_SLOT;
        end else if (!enable_i) begin
            sub <= SUB_LAST;
            slot <= lvds_link_pkg::LAST_SLOT;
        end else if (sub == SUB_LAST) begin
            sub <= '0;
            slot <= (slot == lvds_link_pkg::LAST_SLOT) ? 3'h0 : slot + 3'h1;
        end else begin
            sub <= sub + SUB_W'(1);
        end
    end

    // Word hold, clock and drive enable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold <= '0;
            clk_q <= 1'b0;
            drive <= 1'b0;
        end else begin
            if (load) begin
                hold <= pixel_in_i;
            end
            clk_q <= enable_i && !period_end && (slot < lvds_link_pkg::CLK_HIGH_SLOTS);
            drive <= enable_i;
        end
    end

    // Each lane sends its mapped bits in slot order; absent lanes stay undriven
    for (genvar l = 0; l < lvds_link_pkg::LANES_MAX; l++) begin : g_lane
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                lane_q[l] <= 1'b0;
            end else begin
                lane_q[l] <= hold[lvds_link_pkg::LANE_MAP[l][slot]];
            end
        end
        assign link.tx_lane_oe[l] = drive && (l < NUM_LANES);
    end

    assign link.tx_lane = lane_q;
    assign link.tx_clk = clk_q;
    assign link.tx_clk_oe = drive;
endmodule
`default_nettype wire
